//--- src/motor_io_pkg.sv
/*
 Shared constants and carrier types of the motor driver I/O signal block:
 register offsets, field layouts, reset values and timing counts.
 Assumes a single 125 MHz clock domain and a 32-bit Wishbone slave.
*/
package motor_io_pkg;

  // Clock
  localparam longint CLK_HZ          = 125_000_000;

  // Register byte offsets
  localparam logic [7:0] CONFIG_OFS     = 8'h00;
  localparam logic [7:0] STEP_DIV_OFS   = 8'h04;
  localparam logic [7:0] STATUS_OFS     = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFS   = 8'h0c;
  localparam logic [7:0] IRQ_MASK_OFS   = 8'h10;
  localparam logic [7:0] GEN_CMD_OFS    = 8'h14;
  localparam logic [7:0] GEN_DIR_OFS    = 8'h18;
  localparam logic [7:0] GEN_POL_OFS    = 8'h1c;
  localparam logic [7:0] GEN_REPORT_OFS = 8'h20;
  localparam logic [7:0] ECHO_OFS       = 8'h24;

  // Widths
  localparam int CMD_W  = 22;
  localparam int SENS_W = 4;
  localparam int GEN_W  = 16;
  localparam int ECHO_W = 26;
  localparam int PIN_W  = GEN_W + 1 + SENS_W + CMD_W;
  localparam int GAP_W  = 23;
  localparam int IRQ_W  = 6;

  // Configuration register, bits [6:0]
  typedef struct packed {
    logic slot_use;
    logic three_sensor;
    logic slot_nc;
    logic origin_nc;
    logic limit_nc;
    logic ot_decel;
    logic ot_enable;
  } config_t;

  // Sensor pins, bits [3:0]
  typedef struct packed {
    logic slot;
    logic origin;
    logic neg;
    logic pos;
  } sensor_t;

  // Status register bit positions
  localparam int ST_BUSY    = 0;
  localparam int ST_POWER   = 1;
  localparam int ST_STOP_IM = 2;
  localparam int ST_STOP_DC = 3;
  localparam int ST_INVALID = 4;
  localparam int ST_HOMING  = 5;

  // Interrupt bit positions
  localparam int IRQ_STEP      = 0;
  localparam int IRQ_INVALID   = 1;
  localparam int IRQ_OT_POS    = 2;
  localparam int IRQ_OT_NEG    = 3;
  localparam int IRQ_POWER     = 4;
  localparam int IRQ_BUSY_DONE = 5;

  // Reset values
  localparam config_t     CONFIG_RST   = 7'h01;
  localparam logic [15:0] STEP_DIV_RST = 16'h0014;
  localparam logic [15:0] GEN_RST      = 16'h0000;

  // Timing
  localparam longint STEP_PULSE_NS   = 1000;
  localparam logic [6:0] STEP_PULSE_CYC =
    7'((STEP_PULSE_NS * CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000);
  localparam longint SPEED_LIMIT_RPM = 30;
  localparam longint INCR_PER_REV    = 50;
  localparam int     MIN_INCR_CYC    =
    int'((64'd60 * CLK_HZ) / (SPEED_LIMIT_RPM * INCR_PER_REV));

endpackage

//--- src/motor_driver_io_signals.sv
/*
 Digital I/O signal logic of a stepping motor driver: shaft increment
 pulse, busy and main power flags, input echo, limit/home conditioning,
 overtravel stop, general network signals, Wishbone register file, irq.
 Assumes pins are asynchronous; motor_step_in, homing_active_in and
 maint_busy_in come from logic on clock_in.
*/
// Design decisions made here: the register offsets and the Wishbone register port.
// Overview of operation
// - Pulse the shaft output on every 7.2 degree increment of the shaft.
// - Increments faster than 30 r/min mark the shaft pulse invalid.
// - Busy output stays on while maintenance processing runs.
// - Main power status output follows the detected main power.
// - Each listed input has an echo output copying its state.
// - Echo of motion inputs shows input level, never motor motion.
// - Limits during homing go to the homing logic, no overtravel.
// - Limits outside homing are overtravel and stop the motor.
// - Overtravel enable gates limit overtravel; default enabled.
// - Overtravel action 0 stops immediately, 1 decelerates; default 0.
// - Limit polarity selects normally open or closed; default open.
// - Origin sensor used in 3-sensor mode; polarity selectable.
// - Slot sensor may qualify home detection; polarity selectable.
// - Network command bit 1 turns direct output on, 0 off.
// - Direct input on reports network bit 1; input polarity settable.
`timescale 1ns/1ns
`default_nettype none
module motor_driver_io_signals
  import motor_io_pkg::*;
#(
  parameter int unsigned MIN_INCR_CYCLES = MIN_INCR_CYC
) (
  input  wire logic              clock_in,
  input  wire logic              sys_rst_in,
  input  wire logic [7:0]        wb_adr_in,
  input  wire logic [31:0]       wb_dat_in,
  input  wire logic [3:0]        wb_sel_in,
  input  wire logic              wb_we_in,
  input  wire logic              wb_cyc_in,
  input  wire logic              wb_stb_in,
  output var  logic [31:0]       wb_dat_out,
  output var  logic              wb_ack_out,
  input  wire logic [CMD_W-1:0]  command_pins_in,
  input  wire sensor_t           sensor_pins_in,
  input  wire logic              main_power_in,
  input  wire logic [GEN_W-1:0]  direct_inputs_in,
  input  wire logic              motor_step_in,
  input  wire logic              homing_active_in,
  input  wire logic              maint_busy_in,
  output var  logic              shaft_step_pulse_out,
  output var  logic              pulse_invalid_out,
  output var  logic              internal_busy_out,
  output var  logic              main_power_status_out,
  output var  logic [ECHO_W-1:0] echo_out,
  output var  logic              stop_immediate_out,
  output var  logic              stop_decel_out,
  output var  logic              limit_homing_out,
  output var  logic              origin_detect_out,
  output var  logic [GEN_W-1:0]  direct_outputs_out,
  output var  logic              irq_out
);

  // Pin synchronisers
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] sync_a;
  logic [PIN_W-1:0] sync_b;

  assign pins_raw = {direct_inputs_in, main_power_in,
                     sensor_pins_in, command_pins_in};

  for (genvar i = 0; i < PIN_W; i++) begin : g_sync
    always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
        sync_a[i] <= 1'b0;
        sync_b[i] <= 1'b0;
      end else begin
        sync_a[i] <= pins_raw[i];
        sync_b[i] <= sync_a[i];
      end
    end
  end

  logic [CMD_W-1:0] cmd_lvl;
  sensor_t          sens_pin;
  sensor_t          sens;
  logic             power_lvl;
  logic [GEN_W-1:0] din_lvl;

  config_t          cfg;

  assign cmd_lvl   = sync_b[CMD_W-1:0];
  assign sens_pin  = sensor_t'(sync_b[CMD_W+SENS_W-1:CMD_W]);
  assign power_lvl = sync_b[CMD_W+SENS_W];
  assign din_lvl   = sync_b[PIN_W-1:PIN_W-GEN_W];

  // Contact polarity applied once for all consumers
  assign sens.pos    = sens_pin.pos ^ cfg.limit_nc;
  assign sens.neg    = sens_pin.neg ^ cfg.limit_nc;
  assign sens.origin = sens_pin.origin ^ cfg.origin_nc;
  assign sens.slot   = sens_pin.slot ^ cfg.slot_nc;

  // Register file state
  logic [15:0]      step_div;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [GEN_W-1:0] gen_cmd;
  logic [GEN_W-1:0] gen_dir;
  logic [GEN_W-1:0] gen_pol;
  logic [GEN_W-1:0] gen_report;
  config_t          next_cfg;
  logic [15:0]      next_step_div;
  logic [IRQ_W-1:0] next_irq_stat;
  logic [IRQ_W-1:0] next_irq_mask;
  logic [GEN_W-1:0] next_gen_cmd;
  logic [GEN_W-1:0] next_gen_dir;
  logic [GEN_W-1:0] next_gen_pol;
  logic [GEN_W-1:0] next_gen_report;
  logic [31:0]      next_wb_dat;
  logic             next_wb_ack;
  logic             next_irq;
  logic [IRQ_W-1:0] events;

  // Datapath state
  logic [15:0]       step_cnt;
  logic [6:0]        pulse_cnt;
  logic [GAP_W-1:0]  gap_cnt;
  logic              ot_pos_q;
  logic              ot_neg_q;
  logic [15:0]       next_step_cnt;
  logic [6:0]        next_pulse_cnt;
  logic [GAP_W-1:0]  next_gap_cnt;
  logic              next_ot_pos;
  logic              next_ot_neg;
  logic              next_invalid;
  logic              next_busy;
  logic              next_power;
  logic [ECHO_W-1:0] next_echo;
  logic              next_stop_im;
  logic              next_stop_dc;
  logic              next_limit_homing;
  logic              next_origin;
  logic [GEN_W-1:0]  next_direct;
  logic              incr;
  logic              too_fast;
  logic              ot_live;

  // Datapath next values
  always_comb begin
    incr = motor_step_in && (step_cnt + 16'h0001 >= step_div);
    if (incr) begin
      next_step_cnt = 16'h0000;
    end else if (motor_step_in) begin
      next_step_cnt = step_cnt + 16'h0001;
    end else begin
      next_step_cnt = step_cnt;
    end
    if (incr) begin
      next_pulse_cnt = STEP_PULSE_CYC;
    end else if (pulse_cnt != 7'h00) begin
      next_pulse_cnt = pulse_cnt - 7'h01;
    end else begin
      next_pulse_cnt = 7'h00;
    end
    too_fast = incr
      && (gap_cnt < GAP_W'(MIN_INCR_CYCLES - 1));
    if (incr) begin
      next_gap_cnt = '0;
    end else if (&gap_cnt) begin
      next_gap_cnt = gap_cnt;
    end else begin
      next_gap_cnt = gap_cnt + GAP_W'(1);
    end
    next_invalid = incr ? too_fast : pulse_invalid_out;
    next_busy    = maint_busy_in;
    next_power   = power_lvl;
    next_echo    = {sens.slot, sens.origin, sens.neg, sens.pos,
                    cmd_lvl};
    ot_live = cfg.ot_enable && !homing_active_in
      && (sens.pos || sens.neg);
    next_stop_im = ot_live && !cfg.ot_decel;
    next_stop_dc = ot_live && cfg.ot_decel;
    next_ot_pos  = ot_live && sens.pos;
    next_ot_neg  = ot_live && sens.neg;
    next_limit_homing = homing_active_in && (sens.pos || sens.neg);
    next_origin = cfg.three_sensor && sens.origin
      && (!cfg.slot_use || sens.slot);
    next_direct = gen_cmd & ~gen_dir;
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      step_cnt              <= 16'h0000;
      pulse_cnt             <= 7'h00;
      gap_cnt               <= '1;
      ot_pos_q              <= 1'b0;
      ot_neg_q              <= 1'b0;
      shaft_step_pulse_out  <= 1'b0;
      pulse_invalid_out     <= 1'b0;
      internal_busy_out     <= 1'b0;
      main_power_status_out <= 1'b0;
      echo_out              <= '0;
      stop_immediate_out    <= 1'b0;
      stop_decel_out        <= 1'b0;
      limit_homing_out      <= 1'b0;
      origin_detect_out     <= 1'b0;
      direct_outputs_out    <= '0;
    end else begin
      step_cnt              <= next_step_cnt;
      pulse_cnt             <= next_pulse_cnt;
      gap_cnt               <= next_gap_cnt;
      ot_pos_q              <= next_ot_pos;
      ot_neg_q              <= next_ot_neg;
      shaft_step_pulse_out  <= next_pulse_cnt != 7'h00;
      pulse_invalid_out     <= next_invalid;
      internal_busy_out     <= next_busy;
      main_power_status_out <= next_power;
      echo_out              <= next_echo;
      stop_immediate_out    <= next_stop_im;
      stop_decel_out        <= next_stop_dc;
      limit_homing_out      <= next_limit_homing;
      origin_detect_out     <= next_origin;
      direct_outputs_out    <= next_direct;
    end
  end

  // Bus and register next values
  logic        bus_hit;
  logic        bus_wr;
  logic [31:0] lane_mask;
  logic [31:0] wdat;
  logic [31:0] status_word;

  always_comb begin
    bus_hit   = wb_cyc_in && wb_stb_in && !wb_ack_out;
    bus_wr    = bus_hit && wb_we_in;
    lane_mask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
                 {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
    wdat      = wb_dat_in & lane_mask;
    status_word = '0;
    status_word[ST_BUSY]    = internal_busy_out;
    status_word[ST_POWER]   = main_power_status_out;
    status_word[ST_STOP_IM] = stop_immediate_out;
    status_word[ST_STOP_DC] = stop_decel_out;
    status_word[ST_INVALID] = pulse_invalid_out;
    status_word[ST_HOMING]  = homing_active_in;
    events = '0;
    events[IRQ_STEP]      = incr;
    events[IRQ_INVALID]   = too_fast;
    events[IRQ_OT_POS]    = next_ot_pos && !ot_pos_q;
    events[IRQ_OT_NEG]    = next_ot_neg && !ot_neg_q;
    events[IRQ_POWER]     = power_lvl != main_power_status_out;
    events[IRQ_BUSY_DONE] = internal_busy_out && !maint_busy_in;
    next_cfg        = cfg;
    next_step_div   = step_div;
    next_irq_mask   = irq_mask;
    next_gen_cmd    = gen_cmd;
    next_gen_dir    = gen_dir;
    next_gen_pol    = gen_pol;
    next_irq_stat   = irq_stat | events;
    if (bus_wr) begin
      unique case (wb_adr_in)
        CONFIG_OFS: next_cfg = config_t'(
          (32'(cfg) & ~lane_mask) | wdat);
        STEP_DIV_OFS: next_step_div =
          (step_div & ~lane_mask[15:0]) | wdat[15:0];
        IRQ_STAT_OFS: next_irq_stat =
          (irq_stat & ~wdat[IRQ_W-1:0]) | events;
        IRQ_MASK_OFS: next_irq_mask =
          (irq_mask & ~lane_mask[IRQ_W-1:0]) | wdat[IRQ_W-1:0];
        GEN_CMD_OFS: next_gen_cmd =
          (gen_cmd & ~lane_mask[15:0]) | wdat[15:0];
        GEN_DIR_OFS: next_gen_dir =
          (gen_dir & ~lane_mask[15:0]) | wdat[15:0];
        GEN_POL_OFS: next_gen_pol =
          (gen_pol & ~lane_mask[15:0]) | wdat[15:0];
        default: ;
      endcase
    end
    next_gen_report = (din_lvl ^ gen_pol) & gen_dir;
    next_wb_ack = bus_hit;
    next_wb_dat = '0;
    if (bus_hit && !wb_we_in) begin
      unique case (wb_adr_in)
        CONFIG_OFS:     next_wb_dat = 32'(cfg);
        STEP_DIV_OFS:   next_wb_dat = 32'(step_div);
        STATUS_OFS:     next_wb_dat = status_word;
        IRQ_STAT_OFS:   next_wb_dat = 32'(irq_stat);
        IRQ_MASK_OFS:   next_wb_dat = 32'(irq_mask);
        GEN_CMD_OFS:    next_wb_dat = 32'(gen_cmd);
        GEN_DIR_OFS:    next_wb_dat = 32'(gen_dir);
        GEN_POL_OFS:    next_wb_dat = 32'(gen_pol);
        GEN_REPORT_OFS: next_wb_dat = 32'(gen_report);
        ECHO_OFS:       next_wb_dat = 32'(echo_out);
        default:        next_wb_dat = '0;
      endcase
    end
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      cfg        <= CONFIG_RST;
      step_div   <= STEP_DIV_RST;
      irq_stat   <= '0;
      irq_mask   <= '0;
      gen_cmd    <= GEN_RST;
      gen_dir    <= GEN_RST;
      gen_pol    <= GEN_RST;
      gen_report <= GEN_RST;
      wb_ack_out <= 1'b0;
      wb_dat_out <= '0;
      irq_out    <= 1'b0;
    end else begin
      cfg        <= next_cfg;
      step_div   <= next_step_div;
      irq_stat   <= next_irq_stat;
      irq_mask   <= next_irq_mask;
      gen_cmd    <= next_gen_cmd;
      gen_dir    <= next_gen_dir;
      gen_pol    <= next_gen_pol;
      gen_report <= next_gen_report;
      wb_ack_out <= next_wb_ack;
      wb_dat_out <= next_wb_dat;
      irq_out    <= next_irq;
    end
  end

  // Checks
  property p_step_pulse;
    @(posedge clock_in) disable iff (sys_rst_in)
    incr |=> shaft_step_pulse_out [*8];
  endproperty
  a_step_pulse: assert property (p_step_pulse)
    else $error("shaft pulse not held after increment");
  property p_too_fast;
    @(posedge clock_in) disable iff (sys_rst_in)
    (incr && gap_cnt < GAP_W'(MIN_INCR_CYCLES - 1))
      |=> pulse_invalid_out && shaft_step_pulse_out;
  endproperty
  a_too_fast: assert property (p_too_fast)
    else $error("fast increment not flagged invalid");
  property p_busy;
    @(posedge clock_in) disable iff (sys_rst_in)
    maint_busy_in |=> internal_busy_out;
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy dropped during processing");
  property p_power;
    @(posedge clock_in) disable iff (sys_rst_in)
    $changed(power_lvl) |=> main_power_status_out == $past(power_lvl);
  endproperty
  a_power: assert property (p_power)
    else $error("main power status lags");
  property p_homing_no_stop;
    @(posedge clock_in) disable iff (sys_rst_in)
    (homing_active_in && (sens.pos || sens.neg))
      |=> limit_homing_out && !stop_immediate_out && !stop_decel_out;
  endproperty
  a_homing_no_stop: assert property (p_homing_no_stop)
    else $error("limit during homing handled as overtravel");
  property p_ot_imm;
    @(posedge clock_in) disable iff (sys_rst_in)
    (cfg.ot_enable && !homing_active_in && sens_pin.pos != cfg.limit_nc
      && !cfg.ot_decel) |=> stop_immediate_out && !stop_decel_out;
  endproperty
  a_ot_imm: assert property (p_ot_imm)
    else $error("overtravel immediate stop missing");
  property p_ot_dec;
    @(posedge clock_in) disable iff (sys_rst_in)
    (cfg.ot_enable && !homing_active_in && sens.neg && cfg.ot_decel)
      |=> stop_decel_out && !stop_immediate_out;
  endproperty
  a_ot_dec: assert property (p_ot_dec)
    else $error("overtravel decelerate stop missing");
  property p_ot_off;
    @(posedge clock_in) disable iff (sys_rst_in)
    !cfg.ot_enable |=> !stop_immediate_out && !stop_decel_out;
  endproperty
  a_ot_off: assert property (p_ot_off)
    else $error("stop raised with overtravel disabled");
  property p_net_out;
    @(posedge clock_in) disable iff (sys_rst_in)
    (bus_wr && wb_adr_in == GEN_CMD_OFS && wb_sel_in == 4'hf)
      |=> ##1 direct_outputs_out == ($past(wb_dat_in[15:0], 2) & ~gen_dir);
  endproperty
  a_net_out: assert property (p_net_out)
    else $error("direct output does not follow command bit");
  property p_net_in;
    @(posedge clock_in) disable iff (sys_rst_in)
    (gen_dir[0] && !gen_pol[0] && din_lvl[0]) |=> gen_report[0];
  endproperty
  a_net_in: assert property (p_net_in)
    else $error("report bit not set for active input");

endmodule // motor_driver_io_signals
`default_nettype wire

//--- sim/field_sensors.sv
/*
 Model of the field sensors that wire to the sensor pins.
 Assumes the bench gives the wanted active levels and the contact setup.
*/
`timescale 1ns/1ns
`default_nettype none
module field_sensors
  import motor_io_pkg::*;
(
  input  wire logic [3:0] active_in,
  input  wire config_t    cfg_in,
  output var  sensor_t    pins_out
);
  // Pin level is the active level through the contact type
  always_comb begin
    pins_out.pos    = active_in[0] ^ cfg_in.limit_nc;
    pins_out.neg    = active_in[1] ^ cfg_in.limit_nc;
    pins_out.origin = active_in[2] ^ cfg_in.origin_nc;
    pins_out.slot   = active_in[3] ^ cfg_in.slot_nc;
  end
endmodule // field_sensors
`default_nettype wire

//--- sim/tb.sv
/*
 Self-checking bench of the motor driver I/O signal block.
 Assumes a Wishbone master in the bench and the sensor model beside it.
*/
`timescale 1ns/1ns
`default_nettype none
module tb
  import motor_io_pkg::*;
();
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  sel = 4'h0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic        we = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic [31:0] rdat;
  logic        ack;
  logic [21:0] cmd = 22'h0;
  logic [3:0]  act = 4'h0;
  config_t     cfg = CONFIG_RST;
  sensor_t     pins;
  logic        power = 1'b0;
  logic [15:0] din = 16'h0;
  logic        stp = 1'b0;
  logic        homing = 1'b0;
  logic        maint = 1'b0;
  logic        pulse, invalid, busy, power_stat, s_imm, s_dec, lh, org, irq;
  logic [25:0] echo;
  logic [15:0] dout;
  logic [31:0] q;
  int          bad_count = 0;
  int          tests_run = 0;
  int          cycles = 0;
  localparam logic [15:0] LT [8] = '{
    {7'h01, 1'b0, 4'h1, 4'h1}, {7'h03, 1'b0, 4'h2, 4'h2},
    {7'h00, 1'b0, 4'h1, 4'h0}, {7'h01, 1'b1, 4'h1, 4'h4},
    {7'h05, 1'b0, 4'h1, 4'h1}, {7'h29, 1'b0, 4'h4, 4'h8},
    {7'h69, 1'b0, 4'h4, 4'h0}, {7'h79, 1'b0, 4'hc, 4'h8}};

  always #4 clk = ~clk;

  field_sensors sensors (.active_in(act), .cfg_in(cfg), .pins_out(pins));

  motor_driver_io_signals #(.MIN_INCR_CYCLES(50)) DUT (
    .clock_in(clk), .sys_rst_in(rst), .wb_adr_in(adr), .wb_dat_in(wdat),
    .wb_sel_in(sel), .wb_we_in(we), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_dat_out(rdat), .wb_ack_out(ack), .command_pins_in(cmd),
    .sensor_pins_in(pins), .main_power_in(power), .direct_inputs_in(din),
    .motor_step_in(stp), .homing_active_in(homing),
    .maint_busy_in(maint), .shaft_step_pulse_out(pulse),
    .pulse_invalid_out(invalid), .internal_busy_out(busy),
    .main_power_status_out(power_stat), .echo_out(echo),
    .stop_immediate_out(s_imm), .stop_decel_out(s_dec),
    .limit_homing_out(lh), .origin_detect_out(org),
    .direct_outputs_out(dout), .irq_out(irq));

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    sel <= 4'hf;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
    @(posedge clk);
  endtask

  task automatic step(input int n);
    repeat (n) begin
      stp <= 1'b1;
      @(posedge clk);
      stp <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic s_reset;
    wb(1'b0, CONFIG_OFS, 32'h0);
    check("config", q, 32'h1);
    wb(1'b0, STEP_DIV_OFS, 32'h0);
    check("step div reset", q, 32'h14);
    wb(1'b0, 8'h3c, 32'h0);
    check("unmapped read", q, 32'h0);
  endtask

  task automatic s_shaft;
    wb(1'b1, STEP_DIV_OFS, 32'h2);
    step(1);
    check("no pulse mid increment", pulse, 1'b0);
    step(1);
    check("pulse on increment", pulse, 1'b1);
    tick(124);
    check("pulse still high", pulse, 1'b1);
    tick(1);
    check("pulse ended", pulse, 1'b0);
    check("slow increment valid", invalid, 1'b0);
    step(2);
    step(2);
    check("fast increment invalid", invalid, 1'b1);
    tick(60);
    step(2);
    check("slow increment clears", invalid, 1'b0);
    wb(1'b0, IRQ_STAT_OFS, 32'h0);
    check("irq status", q, 32'h3);
    check("irq masked", irq, 1'b0);
    wb(1'b1, IRQ_MASK_OFS, 32'h2);
    tick(2);
    check("irq raised", irq, 1'b1);
    wb(1'b1, IRQ_STAT_OFS, 32'h3);
    tick(2);
    check("irq cleared", irq, 1'b0);
  endtask

  task automatic s_echo;
    cmd <= 22'h2a5c3f;
    tick(5);
    check("echo", {10'h0, echo[21:0]}, 32'h2a5c3f);
    cmd <= 22'h15a3c0;
    tick(5);
    check("echo inverse", {10'h0, echo[21:0]}, 32'h15a3c0);
  endtask

  task automatic s_limits;
    for (int i = 0; i < 8; i++) begin
      cfg <= config_t'(LT[i][15:9]);
      homing <= LT[i][8];
      act <= LT[i][7:4];
      wb(1'b1, CONFIG_OFS, {25'h0, LT[i][15:9]});
      tick(5);
      check("stops", {28'h0, org, lh, s_dec, s_imm},
            {28'h0, LT[i][3:0]});
      check("homing", {30'h0, org, lh},
            {30'h0, LT[i][3:2]});
      check("sensor echo", {28'h0, echo[25:22]},
            {28'h0, LT[i][7:4]});
    end
    act <= 4'h0;
    homing <= 1'b0;
    tick(5);
    check("stops released", {30'h0, s_dec, s_imm}, 32'h0);
  endtask

  task automatic s_flags;
    maint <= 1'b1;
    power <= 1'b1;
    tick(5);
    check("busy on", busy, 1'b1);
    check("power on", power_stat, 1'b1);
    maint <= 1'b0;
    power <= 1'b0;
    tick(5);
    check("flags off", {30'h0, busy, power_stat}, 32'h0);
  endtask

  task automatic s_general;
    wb(1'b1, GEN_DIR_OFS, 32'hff01);
    wb(1'b1, GEN_POL_OFS, 32'h0f00);
    wb(1'b1, GEN_CMD_OFS, 32'h5aa5);
    check("direct outputs", {16'h0, dout}, 32'h00a4);
    din <= 16'h3c01;
    tick(5);
    wb(1'b0, GEN_REPORT_OFS, 32'h0);
    check("report", q, 32'h3301);
    din <= 16'h3c00;
    tick(5);
    wb(1'b0, GEN_REPORT_OFS, 32'h0);
    check("report input off", q, 32'h3300);
    wb(1'b1, GEN_CMD_OFS, 32'h0);
    check("direct outputs off", {16'h0, dout}, 32'h0);
  endtask

  initial begin
    tick(8);
    rst <= 1'b0;
    s_reset();
    s_shaft();
    s_echo();
    s_limits();
    s_flags();
    s_general();
    complete_run();
  end
endmodule // tb
`default_nettype wire
